//--- pfc_fifo.sv
// Deeply pipelined fifo with fixed request to valid read latency.
// Assumes one system clock feeds both write and read sides, and that the
// user releases the clears in step with that clock.
//
// Functional notes
// (R1) Large block RAM width: 32 times 1..128.
// (R2) Logic array RAM width: 20 times 1..205.
// (R3) User ties off unused write data bits.
// (R4) Single clock mode drops crossing structure.
// (R5) Storage type parameter picks RAM kind.
// (R6) Async clears act only when enabled.
// (R7) Write gray pointer synced 3 or 4.
// (R8) Read gray pointer synced 3 or 4.
// (R9) Optional per block address replication.
// (R10) Single clock drives both sides.
// (R11) Async clear acts directly, unsynchronised.
// (R12) Sync clear clears domain flops.
// (R13) Writer holds request low in reset.
// (R14) Store word only when requested, not full.
// (R15) Full ignores writes, asserts early.
// (R16) Valid exactly L cycles after request.
// (R17) Reader requests only with downstream room.
// (R18) Valid only follows requests; data then.
// (R19) Reader must take every valid word.
// (R20) Empty is pipelined zero fill count.
// (R21) Valid may outlast empty assertion.
// (R22) Active low write protect precedes full.
// (R23) Depth 512 or 32 words per block.
// (R24) Sync clear held 32 slow cycles.
// (R25) Dual clock splits write/read domains.
// (R26) Each side sampled on its clock.
`timescale 1ns/100ps
`default_nettype none
module pfc_fifo #(
    parameter pfc_pkg::pfc_storage_e storage_type_select =
        pfc_pkg::PFC_LARGE_BLOCK_RAM,
    parameter int word_width_param = 32,
    parameter bit single_clock_mode = 1'b0,
    parameter bit use_aclr_port = 1'b0,
    parameter int write_pointer_sync_depth = 3,
    parameter int read_pointer_sync_depth = 3,
    parameter bit write_address_replicate = 1'b0,
    parameter bit read_address_replicate = 1'b0
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire pfc_pkg::pfc_clear_s writeClear,
    input wire pfc_pkg::pfc_clear_s readClear,
    input wire logic writeReq,
    input wire logic [word_width_param-1:0] writeData,
    output logic writeFull,
    output logic writeReady,
    input wire logic readReq,
    output logic [word_width_param-1:0] readData,
    output logic readValid,
    output logic readEmpty
);
    import pfc_pkg::*;

    // ********************************************************************
    // Geometry
    // ********************************************************************
    localparam bit LBR = (storage_type_select == PFC_LARGE_BLOCK_RAM);
    localparam int GRAN = LBR ? PFC_LBR_GRAN : PFC_LAR_GRAN;        // [R5]
    localparam int DEPTH = LBR ? PFC_LBR_DEPTH : PFC_LAR_DEPTH;     // [R23]
    localparam int MULT_MAX = LBR ? PFC_LBR_MULT_MAX : PFC_LAR_MULT_MAX;
    localparam int LAT = LBR ? PFC_LBR_LATENCY : PFC_LAR_LATENCY;
    localparam int NBLK = word_width_param / GRAN;
    localparam int AW = $clog2(DEPTH);
    localparam int PW = AW + 1;
    localparam logic [PW-1:0] FULL_AT = PW'(DEPTH - PFC_FULL_MARGIN);
    localparam logic [PW-1:0] PROT_AT =
        PW'(DEPTH - PFC_FULL_MARGIN - PFC_READY_LEAD);

    // Refuse widths the block grid cannot hold.
    if (word_width_param % GRAN != 0 || NBLK < PFC_MULT_DEFAULT ||
        NBLK > MULT_MAX) begin : g_bad_width
        $error("pfc_fifo: width must be a legal multiple of the granule.");
    end                                                          // [R1] [R2]
    if (write_pointer_sync_depth < PFC_SYNC_MIN ||
        write_pointer_sync_depth > PFC_SYNC_MAX ||
        read_pointer_sync_depth < PFC_SYNC_MIN ||
        read_pointer_sync_depth > PFC_SYNC_MAX) begin : g_bad_sync
        $error("pfc_fifo: synchroniser depth must be 3 or 4.");
    end

    function automatic logic [PW-1:0] toGray(input logic [PW-1:0] b);
        toGray = b ^ (b >> 1);
    endfunction

    function automatic logic [PW-1:0] fromGray(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b[PW-1] = g[PW-1];
        for (int i = PW - 2; i >= 0; i--) begin
            b[i] = g[i] ^ b[i+1];
        end
        fromGray = b;
    endfunction

    // ********************************************************************
    // Clears
    // ********************************************************************
    // The async clears bypass any synchroniser, so a late release is the
    // user's hazard; when the port is disabled they are ignored entirely.
    logic wClrN;
    logic rClrN;
    assign wClrN = resetn & ~(use_aclr_port & writeClear.aclr); // [R6] [R11]
    assign rClrN = resetn & ~(use_aclr_port & readClear.aclr);  // [R6] [R11]

    // ********************************************************************
    // Pointer exchange
    // ********************************************************************
    logic [PW-1:0] wPtr_ff;
    logic [PW-1:0] rPtr_ff;
    logic [PW-1:0] wGray_ff;
    logic [PW-1:0] rGray_ff;
    logic [PW-1:0] wGrayAtRd;
    logic [PW-1:0] rGrayAtWr;
    logic [PW-1:0] wPtrAtRd;
    logic [PW-1:0] rPtrAtWr;

    if (single_clock_mode) begin : g_single
        // Same clock on both sides: no crossing, pointers used directly.
        assign wPtrAtRd = wPtr_ff;                               // [R4] [R10]
        assign rPtrAtWr = rPtr_ff;
        assign wGrayAtRd = wGray_ff;
        assign rGrayAtWr = rGray_ff;
    end else begin : g_dual
        // The two sides are treated as unrelated and cross in gray code.
        pfc_ptr_sync #(
            .WIDTH(PW),
            .STAGES(write_pointer_sync_depth)
        ) u_wptr_sync (
            .clk_sys(clk_sys),
            .clrN(rClrN),
            .sclr(readClear.sclr),
            .grayIn(wGray_ff),
            .grayOut(wGrayAtRd)
        );                                                       // [R7] [R25]
        pfc_ptr_sync #(
            .WIDTH(PW),
            .STAGES(read_pointer_sync_depth)
        ) u_rptr_sync (
            .clk_sys(clk_sys),
            .clrN(wClrN),
            .sclr(writeClear.sclr),
            .grayIn(rGray_ff),
            .grayOut(rGrayAtWr)
        );                                                       // [R8] [R25]
        assign wPtrAtRd = fromGray(wGrayAtRd);
        assign rPtrAtWr = fromGray(rGrayAtWr);
    end

    // ********************************************************************
    // Write side
    // ********************************************************************
    logic [PW-1:0] nxt_wPtr;
    logic [PW-1:0] nxt_wGray;
    logic [AW-1:0] wAddrRep_ff [NBLK];
    logic [AW-1:0] nxt_wAddrRep [NBLK];
    logic wFull_ff;
    logic nxt_wFull;
    logic wReady_ff;
    logic nxt_wReady;
    logic wAccept;
    logic [PW-1:0] wUsed;

    // Count is pessimistic: the read pointer arrives late, so full holds
    // back a few entries to cover writes already past the flag.
    always_comb begin
        wAccept = writeReq && !wFull_ff;                       // [R14] [R15]
        wUsed = wPtr_ff - rPtrAtWr;
        nxt_wPtr = wPtr_ff + PW'(wAccept);
        nxt_wGray = toGray(wPtr_ff);
        nxt_wFull = (wUsed >= FULL_AT);                               // [R15]
        nxt_wReady = (wUsed < PROT_AT);                               // [R22]
        for (int b = 0; b < NBLK; b++) begin
            nxt_wAddrRep[b] = nxt_wPtr[AW-1:0];                        // [R9]
        end
        if (writeClear.sclr) begin
            nxt_wPtr = '0;                                            // [R12]
            nxt_wGray = '0;
            nxt_wFull = PFC_FULL_RST;
            nxt_wReady = PFC_READY_RST;
            for (int b = 0; b < NBLK; b++) begin
                nxt_wAddrRep[b] = '0;
            end
        end
    end

    // Write-side registers, sampled on the write clock.
    always_ff @(posedge clk_sys or negedge wClrN) begin               // [R26]
        if (!wClrN) begin
            wPtr_ff <= '0;
            wGray_ff <= '0;
            wFull_ff <= PFC_FULL_RST;
            wReady_ff <= PFC_READY_RST;
            for (int b = 0; b < NBLK; b++) begin
                wAddrRep_ff[b] <= '0;
            end
        end else begin
            wPtr_ff <= nxt_wPtr;
            wGray_ff <= nxt_wGray;
            wFull_ff <= nxt_wFull;
            wReady_ff <= nxt_wReady;
            wAddrRep_ff <= nxt_wAddrRep;
        end
    end

    assign writeFull = wFull_ff;
    assign writeReady = wReady_ff;

    // ********************************************************************
    // Read side
    // ********************************************************************
    logic [PW-1:0] nxt_rPtr;
    logic [PW-1:0] nxt_rGray;
    logic [AW-1:0] rAddrRep_ff [NBLK];
    logic [AW-1:0] nxt_rAddrRep [NBLK];
    logic [LAT-1:0] vPipe_ff;
    logic [LAT-1:0] nxt_vPipe;
    logic rEmpty_ff;
    logic nxt_rEmpty;
    logic rHit;
    logic [PW-1:0] rFill;

    // A request only pops when the fill seen here is nonzero; a miss
    // still walks the pipe so the answer keeps its fixed slot.
    always_comb begin
        rFill = wPtrAtRd - rPtr_ff;
        rHit = readReq && (rFill != '0);                       // [R18] [R17]
        nxt_rPtr = rPtr_ff + PW'(rHit);
        nxt_rGray = toGray(rPtr_ff);
        nxt_vPipe = {vPipe_ff[LAT-2:0], rHit};                        // [R16]
        nxt_rEmpty = (rFill == '0);                             // [R20] [R21]
        for (int b = 0; b < NBLK; b++) begin
            nxt_rAddrRep[b] = nxt_rPtr[AW-1:0];                        // [R9]
        end
        if (readClear.sclr) begin
            nxt_rPtr = '0;                                            // [R12]
            nxt_rGray = '0;
            nxt_vPipe = '0;
            nxt_rEmpty = PFC_EMPTY_RST;
            for (int b = 0; b < NBLK; b++) begin
                nxt_rAddrRep[b] = '0;
            end
        end
    end

    // Read-side control registers, sampled on the read clock.
    always_ff @(posedge clk_sys or negedge rClrN) begin               // [R26]
        if (!rClrN) begin
            rPtr_ff <= '0;
            rGray_ff <= '0;
            vPipe_ff <= '0;
            rEmpty_ff <= PFC_EMPTY_RST;
            for (int b = 0; b < NBLK; b++) begin
                rAddrRep_ff[b] <= '0;
            end
        end else begin
            rPtr_ff <= nxt_rPtr;
            rGray_ff <= nxt_rGray;
            vPipe_ff <= nxt_vPipe;
            rEmpty_ff <= nxt_rEmpty;
            rAddrRep_ff <= nxt_rAddrRep;
        end
    end

    // ********************************************************************
    // Storage blocks
    // ********************************************************************
    logic [word_width_param-1:0] ramOut;

    for (genvar g = 0; g < NBLK; g++) begin : g_blk
        // Each block owns its array; replicated addresses trade area for
        // shorter fan-out from a single pointer register.
        logic [GRAN-1:0] mem [DEPTH];
        logic [GRAN-1:0] memQ;
        logic [AW-1:0] wAddr;
        logic [AW-1:0] rAddr;
        assign wAddr = write_address_replicate ? wAddrRep_ff[g]
                                               : wPtr_ff[AW-1:0];  // [R9]
        assign rAddr = read_address_replicate ? rAddrRep_ff[g]
                                              : rPtr_ff[AW-1:0];   // [R9]

        // Array write and registered read; contents are not reset.
        always_ff @(posedge clk_sys) begin
            if (wAccept && !writeClear.sclr) begin
                mem[wAddr] <= writeData[g*GRAN +: GRAN];              // [R14]
            end
            if (rHit) begin
                memQ <= mem[rAddr];
            end
        end
        assign ramOut[g*GRAN +: GRAN] = memQ;
    end

    // ********************************************************************
    // Read data pipe
    // ********************************************************************
    // Stage zero is the array output; the rest only delay it to line up
    // with the valid pipe, the price of a fixed latency.
    logic [word_width_param-1:0] dPipe_ff [1:LAT-1];
    logic [word_width_param-1:0] nxt_dPipe [1:LAT-1];

    always_comb begin
        nxt_dPipe[1] = ramOut;                                        // [R16]
        for (int s = 2; s < LAT; s++) begin
            nxt_dPipe[s] = dPipe_ff[s-1];
        end
    end

    // Data pipe registers.
    always_ff @(posedge clk_sys or negedge rClrN) begin
        if (!rClrN) begin
            for (int s = 1; s < LAT; s++) begin
                dPipe_ff[s] <= '0;
            end
        end else begin
            dPipe_ff <= nxt_dPipe;
        end
    end

    assign readData = dPipe_ff[LAT-1];                                // [R18]
    assign readValid = vPipe_ff[LAT-1];                         // [R16] [R21]
    assign readEmpty = rEmpty_ff;

endmodule
`default_nettype wire

//--- pfc_pkg.sv
// Package of constants and types shared by the pipelined fifo files.
// Assumes a single system clock; nothing else is needed by the importers.
package pfc_pkg;

    // ********************************************************************
    // Storage choices
    // ********************************************************************
    typedef enum logic {
        PFC_LARGE_BLOCK_RAM,
        PFC_LOGIC_ARRAY_RAM
    } pfc_storage_e;

    // Width granule, word count and multiplier limit per storage kind.
    localparam int PFC_LBR_GRAN = 32;
    localparam int PFC_LBR_DEPTH = 512;
    localparam int PFC_LBR_MULT_MAX = 128;
    localparam int PFC_LAR_GRAN = 20;
    localparam int PFC_LAR_DEPTH = 32;
    localparam int PFC_LAR_MULT_MAX = 205;
    localparam int PFC_MULT_DEFAULT = 1;

    // Request to valid latency in clock cycles per storage kind.
    localparam int PFC_LBR_LATENCY = 6;
    localparam int PFC_LAR_LATENCY = 5;

    // ********************************************************************
    // Clock crossing and flow control
    // ********************************************************************
    localparam int PFC_SYNC_DEFAULT = 3;
    localparam int PFC_SYNC_MIN = 3;
    localparam int PFC_SYNC_MAX = 4;
    // Entries held back from the depth before full asserts.
    localparam int PFC_FULL_MARGIN = 4;
    // Write protect drops this many entries earlier than full.
    localparam int PFC_READY_LEAD = 2;
    // Sync clear hold that flushes unreset state, in slow clock cycles.
    localparam int PFC_FLUSH_CYCLES = 32;

    // Reset values of the status flags.
    localparam logic PFC_FULL_RST = 1'b0;
    localparam logic PFC_READY_RST = 1'b0;
    localparam logic PFC_EMPTY_RST = 1'b1;
    localparam logic PFC_VALID_RST = 1'b0;

    // Per-domain clear pair: asynchronous and synchronous, active high.
    typedef struct packed {
        logic aclr;
        logic sclr;
    } pfc_clear_s;

endpackage

//--- pfc_ptr_sync.sv
// Multi-flop synchroniser for a gray-coded pointer.
// Assumes the source changes by at most one bit per update.
`timescale 1ns/100ps
`default_nettype none
module pfc_ptr_sync #(
    parameter int WIDTH = 10,
    parameter int STAGES = 3
) (
    input wire logic clk_sys,
    input wire logic clrN,
    input wire logic sclr,
    input wire logic [WIDTH-1:0] grayIn,
    output logic [WIDTH-1:0] grayOut
);

    // ********************************************************************
    // Chain
    // ********************************************************************
    logic [WIDTH-1:0] chain_ff [STAGES];
    logic [WIDTH-1:0] nxt_chain [STAGES];

    if (STAGES < 3 || STAGES > 4) begin : g_bad_stages
        $error("pfc_ptr_sync: stage count must be 3 or 4.");
    end

    // Shift along; only stage one looks at the foreign value.
    always_comb begin
        for (int i = 0; i < STAGES; i++) begin
            if (sclr) begin
                nxt_chain[i] = '0;
            end else if (i == 0) begin
                nxt_chain[i] = grayIn;
            end else begin
                nxt_chain[i] = chain_ff[i-1];
            end
        end
    end

    // Register the chain.
    always_ff @(posedge clk_sys or negedge clrN) begin
        if (!clrN) begin
            for (int i = 0; i < STAGES; i++) begin
                chain_ff[i] <= '0;
            end
        end else begin
            chain_ff <= nxt_chain;
        end
    end

    assign grayOut = chain_ff[STAGES-1];

endmodule
`default_nettype wire

//--- pfc_fifo_props.sv
// Concurrent checks on the ports of the pipelined fifo.
// Assumes one clock, clk_sys, and the async active-low resetn.
`timescale 1ns/100ps
`default_nettype none
module pfc_fifo_props #(
    parameter int LAT = 6
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire pfc_pkg::pfc_clear_s writeClear,
    input wire pfc_pkg::pfc_clear_s readClear,
    input wire logic writeReq,
    input wire logic writeFull,
    input wire logic writeReady,
    input wire logic readReq,
    input wire logic readValid,
    input wire logic readEmpty
);
    import pfc_pkg::*;
    // ****************************************************************
    // Port relations
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    logic bothClr;
    // Clears are only sound together, as one side alone skews the fill.
    assign bothClr = writeClear.sclr && readClear.sclr;
    chk_valid_after_req: assert property (
        readValid |-> $past(readReq, LAT))
        else $error("read valid without a request L cycles before");
    chk_reset_state: assert property (
        $rose(resetn) |-> readEmpty && !readValid && !writeFull)
        else $error("flags wrong at reset release");
    chk_ready_leads_full: assert property (
        writeFull |-> !writeReady)
        else $error("write protect not active while full");
    chk_ready_rise_ok: assert property (
        $rose(writeReady) |-> !writeFull)
        else $error("write protect released while full");
    chk_full_from_write: assert property (
        $rose(writeFull) |->
            ($past(writeReq) || $past(writeReq, 2) || $past(writeReq, 3)))
        else $error("full rose without a recent write");
    chk_empty_quiet: assert property (
        readEmpty [*8] |-> !readValid)
        else $error("valid long after empty");
    chk_read_sclr: assert property (
        bothClr [*8] |-> readEmpty && !readValid)
        else $error("read side not cleared by sync clear");
    chk_write_sclr: assert property (
        bothClr [*8] |-> !writeFull)
        else $error("write side not cleared by sync clear");
endmodule
`default_nettype wire

//--- pfc_reader_model.sv
// Downstream reader with a small local buffer that drains at will.
// Assumes the fifo's fixed request to valid latency LAT.
`timescale 1ns/100ps
`default_nettype none
module pfc_reader_model #(
    parameter int LAT = 6,
    parameter int ROOM = 8,
    parameter int W = 32
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic enable,
    input wire logic drain,
    input wire logic readValid,
    input wire logic [W-1:0] readData,
    output logic readReq,
    output logic takeValid,
    output logic [W-1:0] takeData
);
    import pfc_pkg::*;
    // ****************************************************************
    // Request pacing
    // ****************************************************************
    logic [LAT-1:0] flight_ff;
    int held_ff;
    logic room;
    // Count every word that may still land, so none can overflow.
    assign room = ($countones(flight_ff) + int'(readReq) + held_ff)
        < ROOM;
    // Every valid word is taken in its own cycle; no back pressure.
    assign takeValid = readValid;
    assign takeData = readData;
    // Requests are issued just after an edge and held one cycle.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            readReq <= 1'b0;
            flight_ff <= '0;
            held_ff <= 0;
        end else begin
            readReq <= enable && room;
            flight_ff <= {flight_ff[LAT-2:0], readReq};
            held_ff <= held_ff + int'(readValid) - int'(drain && held_ff > 0);
        end
    end
endmodule
`default_nettype wire

//--- pfc_fifo_test.sv
// Self-checking bench for the pipelined fifo with a reader model.
// Assumes one clk_sys; a default build plus a second build that covers
// single clock, logic array RAM, clear port and address replication.
`timescale 1ns/100ps
`default_nettype none
module pfc_fifo_test;
    import pfc_pkg::*;
    // ****************************************************************
    // Stimulus and scoreboard
    // ****************************************************************
    localparam int LAT = PFC_LBR_LATENCY;
    localparam int DEPTH = PFC_LBR_DEPTH;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    pfc_clear_s writeClear = '0;
    pfc_clear_s readClear = '0;
    logic writeReq = 1'b0;
    logic [31:0] writeData = '0;
    logic rdEnable = 1'b0;
    logic rdDrain = 1'b0;
    logic writeFull, writeReady, readReq, readValid, readEmpty, takeValid;
    logic [31:0] readData, takeData;
    logic writeFull2, writeReady2, readReq2, readValid2, readEmpty2;
    logic takeValid2;
    logic [39:0] readData2, takeData2;
    logic [31:0] expQ2[$];
    logic [31:0] rng = 32'h848a;
    logic [31:0] expQ[$];
    logic [LAT-1:0] reqHist = '0;
    int n_errors = 0;
    int total_checks = 0;
    int accepted = 0;
    initial forever #20 clk_sys = ~clk_sys;
    pfc_fifo i_pfc_fifo (.clk_sys(clk_sys), .resetn(resetn),
        .writeClear(writeClear), .readClear(readClear),
        .writeReq(writeReq), .writeData(writeData), .writeFull(writeFull),
        .writeReady(writeReady), .readReq(readReq), .readData(readData),
        .readValid(readValid), .readEmpty(readEmpty));
    pfc_reader_model #(.LAT(LAT)) i_pfc_reader_model (.clk_sys(clk_sys),
        .resetn(resetn), .enable(rdEnable), .drain(rdDrain),
        .readValid(readValid), .readData(readData), .readReq(readReq),
        .takeValid(takeValid), .takeData(takeData));
    // Second build on the same writer: two blocks, so the replicated
    // addresses matter, and the clear port is live for a mid-run reset.
    pfc_fifo #(.storage_type_select(PFC_LOGIC_ARRAY_RAM),
        .word_width_param(40), .single_clock_mode(1'b1),
        .use_aclr_port(1'b1), .write_address_replicate(1'b1),
        .read_address_replicate(1'b1)) i_pfc_fifo_b (.clk_sys(clk_sys),
        .resetn(resetn), .writeClear(writeClear), .readClear(readClear),
        .writeReq(writeReq), .writeData({8'h00, writeData}),
        .writeFull(writeFull2), .writeReady(writeReady2),
        .readReq(readReq2), .readData(readData2),
        .readValid(readValid2), .readEmpty(readEmpty2));
    pfc_reader_model #(.LAT(PFC_LAR_LATENCY), .W(40)) i_pfc_reader_model_b (
        .clk_sys(clk_sys), .resetn(resetn), .enable(rdEnable),
        .drain(rdDrain), .readValid(readValid2), .readData(readData2),
        .readReq(readReq2), .takeValid(takeValid2), .takeData(takeData2));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // Only 24 bits carry data; the rest are tied off by the writer.
    function automatic logic [31:0] tie24(input logic [31:0] s);
        return {8'h00, s[23:0]};
    endfunction
    task automatic check_bit(input string what, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic check_word(input string what, input logic [31:0] e,
        input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Random writes at a rate out of 16, random downstream stalls.
    task automatic traffic(input int n, input int rate, input logic rd);
        repeat (n) begin
            @(posedge clk_sys);
            rng = xs(rng);
            writeReq <= (rng[3:0] < rate);
            writeData <= tie24(rng);
            rdDrain <= rng[9];
            rdEnable <= rd;
        end
        @(posedge clk_sys);
        writeReq <= 1'b0;
    endtask
    task automatic drain_all(input int limit);
        rdEnable <= 1'b1;
        rdDrain <= 1'b1;
        repeat (limit) begin
            @(posedge clk_sys);
            if (expQ.size() == 0 && readEmpty === 1'b1 &&
                expQ2.size() == 0 && readEmpty2 === 1'b1) break;
        end
        tick(LAT + 4);
        check_bit("all words out", 1'b1, expQ.size() == 0);
        check_bit("empty flag", 1'b1, readEmpty);
        check_bit("all words out b", 1'b1, expQ2.size() == 0);
        check_bit("empty flag b", 1'b1, readEmpty2);
    endtask
    // Writes accepted at an edge are queued; every valid must match.
    always @(posedge clk_sys) begin
        if (writeReq && !writeFull && !writeClear.sclr) begin
            expQ.push_back(writeData);
            accepted++;
        end
        if (takeValid) begin
            check_bit("valid slot", 1'b1, reqHist[LAT-1]);
            if (expQ.size() == 0) begin
                check_bit("spare valid", 1'b0, 1'b1);
            end else begin
                check_word("read word", expQ.pop_front(), takeData);
            end
        end
        // The second build also drops its words under its live clear.
        if (writeReq && !writeFull2 && !writeClear.sclr &&
            !writeClear.aclr) begin
            expQ2.push_back(writeData);
        end
        if (takeValid2) begin
            if (expQ2.size() == 0) begin
                check_bit("spare valid b", 1'b0, 1'b1);
            end else begin
                check_word("read word b", expQ2.pop_front(),
                    takeData2[31:0]);
            end
        end
        reqHist <= {reqHist[LAT-2:0], readReq};
    end
    initial begin
        #(40 * 12000);
        n_errors++;
        close_out();
    end
    initial begin
        tick(5);
        resetn <= 1'b1;
        tick(2);
        check_bit("empty at reset", 1'b1, readEmpty);
        check_bit("full at reset", 1'b0, writeFull);
        check_bit("ready after reset", 1'b1, writeReady);
        $display("test reset done");
        traffic(300, 6, 1'b1);
        writeClear.aclr <= 1'b1;
        readClear.aclr <= 1'b1;
        tick(3);
        check_bit("empty under aclr b", 1'b1, readEmpty2);
        writeClear.aclr <= 1'b0;
        readClear.aclr <= 1'b0;
        expQ2.delete();
        drain_all(2000);
        $display("test traffic done");
        accepted = 0;
        traffic(700, 16, 1'b0);
        check_bit("full flag", 1'b1, writeFull);
        check_bit("write protect", 1'b0, writeReady);
        check_bit("full flag b", 1'b1, writeFull2);
        check_bit("write protect b", 1'b0, writeReady2);
        check_bit("capacity", 1'b1, accepted >= DEPTH - PFC_FULL_MARGIN
            && accepted < DEPTH);
        drain_all(3000);
        $display("test fill done");
        traffic(40, 16, 1'b0);
        writeClear.sclr <= 1'b1;
        readClear.sclr <= 1'b1;
        tick(PFC_FLUSH_CYCLES);
        writeClear.sclr <= 1'b0;
        readClear.sclr <= 1'b0;
        expQ.delete();
        expQ2.delete();
        tick(LAT + 8);
        check_bit("empty after clear", 1'b1, readEmpty);
        check_bit("full after clear", 1'b0, writeFull);
        check_bit("empty after clear b", 1'b1, readEmpty2);
        traffic(100, 8, 1'b1);
        drain_all(1000);
        $display("test clear done");
        close_out();
    end
endmodule
bind pfc_fifo pfc_fifo_props #(.LAT(storage_type_select ==
    pfc_pkg::PFC_LARGE_BLOCK_RAM ? pfc_pkg::PFC_LBR_LATENCY :
    pfc_pkg::PFC_LAR_LATENCY)) i_pfc_fifo_props (.clk_sys(clk_sys),
    .resetn(resetn), .writeClear(writeClear), .readClear(readClear),
    .writeReq(writeReq), .writeFull(writeFull), .writeReady(writeReady),
    .readReq(readReq), .readValid(readValid), .readEmpty(readEmpty));
`default_nettype wire
